// ===== logic/acr_pkg.sv
// package of constants and types for the converter conversion and read-out block
// Summary of operation
// RQ1 - every conversion lasts exactly thirteen periods of the selected conversion clock; code pauses the count while the fifo is full
// RQ2 - host keeps external conversion clock between 100kHz and 20MHz
// RQ3 - strap high selects internal oscillator, external clock pin ignored
// RQ4 - strap low selects external clock pin for conversions
// RQ5 - track while start low, sample at rising edge, internal mode converts then
// RQ6 - host holds start low at least 100ns and at most 1ms
// RQ7 - host delivers first external clock pulse within 10us of sampling
// RQ8 - external mode: both done flags fall at rising edge of thirteenth clock; code holds them high while the fifo is full
// RQ9 - internal mode: done flags fall within 900ns of start rising edge; code holds them high while the fifo is full
// RQ10 - both done flags pulse low whenever a new result is ready
// RQ11 - per-conversion flag rises at next external clock edge or start fall
// RQ12 - last-conversion flag stays low until start falls for next sequence
// RQ13 - host keeps start high until it has read the result
// RQ14 - start falling mid-conversion aborts it and begins a new acquisition
// RQ15 - host keeps data bus quiet 50ns before each start falling edge
// RQ16 - result bus driven only while select and read both low
// RQ17 - host lowers select and read after a done flag; raising read releases
// RQ18 - select held low, around reads, or tied to read behave identically
// RQ19 - power-down high shuts analog parts and holds both done flags high
// RQ20 - result bus drive is independent of power-down
// RQ21 - falling edge of power-down launches a conversion like start rising
// RQ22 - host discards first result after power-down exit and waits 1ms
// RQ23 - host waits 1ms after power-up and discards first result
// RQ24 - count clock edges from sampling, load result at thirteen, hold until next
package acr_pkg;
	localparam int ACR_DATA_W = 12;
	localparam int ACR_CONV_CYCLES = 13;
	localparam int ACR_CNT_W = 4;
	localparam int ACR_CLK_MHZ = 100;
	// internal oscillator period in system clocks (about 16.7 MHz, keeps 13 ticks under 900 ns)
	localparam int ACR_INT_DIV = 6;
	localparam int ACR_EOC_MAX_NS = 900;
	localparam int ACR_EOC_MAX_CYC = (ACR_EOC_MAX_NS * ACR_CLK_MHZ) / 1000;
	localparam logic [ACR_DATA_W-1:0] ACR_RESULT_RST = 12'h000;
	localparam int ACR_FIFO_DEPTH = 8;
	typedef enum logic [3:0] {
		ACR_IDLE = 4'b0001,
		ACR_TRACK = 4'b0010,
		ACR_CONV = 4'b0100,
		ACR_DONE = 4'b1000
	} acr_state_t;
endpackage

// ===== logic/acr_fifo.sv
// parameterised sample fifo with valid and ready on both sides
`timescale 1ns/1ps
module acr_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	input wire logic [WIDTH-1:0] in_data, // write word
	output logic out_valid, // not empty
	input wire logic out_ready, // read accept
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic wr, rd;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;

	always_comb begin
		wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
		rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q;
		if (wr && !rd) begin
			cnt_d = (AW+1)'(cnt_q + 1'b1);
		end else if (rd && !wr) begin
			cnt_d = (AW+1)'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wr) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule

// ===== logic/acr_core.sv
// conversion sequencer, done flags and tri-state result read-out
`timescale 1ns/1ps
module acr_core
	import acr_pkg::*;
#(
	parameter int DATA_W = ACR_DATA_W,
	parameter int FIFO_DEPTH = ACR_FIFO_DEPTH
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic sample_start, // conversion start pin
	input wire logic conv_clk_ext, // external conversion clock pin
	input wire logic clock_source_select, // strap: 1 internal, 0 external
	input wire logic power_down, // shutdown pin
	input wire logic chip_sel_n, // chip select, active low
	input wire logic read_n, // read strobe, active low
	input wire logic [DATA_W-1:0] sample_value, // quantised input from converter array
	output logic conv_done_n, // per-conversion done flag
	output logic last_conv_done_n, // last-conversion done flag
	output logic [DATA_W-1:0] result_bus_o, // result bus output value
	output logic result_bus_oe, // result bus output enable
	output logic sample_ready // fifo can accept a sample
);
	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	logic [1:0] st_s1_q, ck_s1_q, pd_s1_q, cs_s1_q, rd_s1_q;
	logic st_q, ck_q, pd_q, cs_q, rd_q;
	logic st_prev_q, ck_prev_q, pd_prev_q;
	logic st_rise, st_fall, ck_rise, pd_fall;
	// edges are ignored until the synchronisers hold real pin samples
	logic sync_ok;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_s1_q <= 2'h0;
			ck_s1_q <= 2'h0;
			pd_s1_q <= 2'h0;
			cs_s1_q <= 2'h3;
			rd_s1_q <= 2'h3;
			st_prev_q <= 1'b0;
			ck_prev_q <= 1'b0;
			pd_prev_q <= 1'b0;
		end else begin
			st_s1_q <= {st_s1_q[0], sample_start};
			ck_s1_q <= {ck_s1_q[0], conv_clk_ext};
			pd_s1_q <= {pd_s1_q[0], power_down};
			cs_s1_q <= {cs_s1_q[0], chip_sel_n};
			rd_s1_q <= {rd_s1_q[0], read_n};
			st_prev_q <= st_q;
			ck_prev_q <= ck_q;
			pd_prev_q <= pd_q;
		end
	end

	assign st_q = st_s1_q[1];
	assign ck_q = ck_s1_q[1];
	assign pd_q = pd_s1_q[1];
	assign cs_q = cs_s1_q[1];
	assign rd_q = rd_s1_q[1];
	assign st_rise = sync_ok && st_q && !st_prev_q;
	assign st_fall = sync_ok && !st_q && st_prev_q;
	assign ck_rise = sync_ok && ck_q && !ck_prev_q;
	assign pd_fall = sync_ok && !pd_q && pd_prev_q;

	//------------------------------------------------------------
	// strap capture after reset release
	//------------------------------------------------------------
	logic [1:0] sel_s_q;
	logic [2:0] strap_age_q;
	logic int_mode_q, int_mode_d;

	// strap is taken once the synchroniser holds a real sample, then frozen
	always_comb begin
		int_mode_d = strap_age_q[2] ? int_mode_q : sel_s_q[1];
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sel_s_q <= 2'h0;
			int_mode_q <= 1'b0;
			strap_age_q <= 3'h0;
		end else begin
			sel_s_q <= {sel_s_q[0], clock_source_select};
			int_mode_q <= int_mode_d;
			strap_age_q <= {strap_age_q[1:0], 1'b1};
		end
	end

	assign sync_ok = strap_age_q[2];

	//------------------------------------------------------------
	// internal oscillator
	//------------------------------------------------------------
	logic [2:0] osc_q, osc_d;
	logic osc_tick, conv_tick;

	always_comb begin
		osc_d = (osc_q == 3'(ACR_INT_DIV - 1)) ? 3'h0 : 3'(osc_q + 1'b1);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			osc_q <= 3'h0;
		end else begin
			osc_q <= osc_d;
		end
	end

	assign osc_tick = (osc_q == 3'h0);
	// selected conversion clock edge
	assign conv_tick = int_mode_q ? osc_tick : ck_rise; // RQ3 RQ4

	//------------------------------------------------------------
	// conversion sequencer
	//------------------------------------------------------------
	acr_state_t state_q, state_d;
	logic [ACR_CNT_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] held_q, held_d;
	logic [DATA_W-1:0] result_q, result_d;
	logic eoc_n_q, eoc_n_d, last_conv_done_n_n_q, last_conv_done_n_n_d;
	logic launch, fifo_push, fifo_ready;

	// start rising edge or shutdown exit samples and launches
	assign launch = (st_rise && !pd_q) || pd_fall; // RQ5 RQ21

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		held_d = held_q;
		result_d = result_q;
		eoc_n_d = eoc_n_q;
		last_conv_done_n_n_d = last_conv_done_n_n_q;
		fifo_push = 1'b0;
		if (st_fall) begin
			eoc_n_d = 1'b1; // RQ11
			last_conv_done_n_n_d = 1'b1; // RQ12
		end else if (ck_rise && !int_mode_q && state_q != ACR_CONV) begin
			eoc_n_d = 1'b1; // RQ11
		end
		case (state_q)
			ACR_IDLE, ACR_DONE: begin
				if (st_fall) begin
					state_d = ACR_TRACK;
				end else if (launch) begin
					held_d = sample_value;
					cnt_d = '0;
					state_d = ACR_CONV;
				end
			end
			ACR_TRACK: begin
				if (launch) begin
					held_d = sample_value; // RQ5
					cnt_d = '0;
					state_d = ACR_CONV;
				end
			end
			ACR_CONV: begin
				if (st_fall) begin
					state_d = ACR_TRACK; // RQ14
				end else if (conv_tick && fifo_ready) begin
					cnt_d = ACR_CNT_W'(cnt_q + 1'b1);
					if (cnt_q == ACR_CNT_W'(ACR_CONV_CYCLES - 1)) begin
						result_d = held_q; // RQ24
						fifo_push = 1'b1;
						eoc_n_d = 1'b0; // RQ1 RQ8 RQ9 RQ10
						last_conv_done_n_n_d = 1'b0; // RQ10
						state_d = ACR_DONE;
					end
				end
			end
			default: begin
				state_d = ACR_IDLE;
			end
		endcase
		if (pd_q) begin
			eoc_n_d = 1'b1; // RQ19
			last_conv_done_n_n_d = 1'b1; // RQ19
			state_d = ACR_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= ACR_IDLE;
			cnt_q <= '0;
			held_q <= ACR_RESULT_RST;
			result_q <= ACR_RESULT_RST;
			eoc_n_q <= 1'b1;
			last_conv_done_n_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			held_q <= held_d;
			result_q <= result_d;
			eoc_n_q <= eoc_n_d;
			last_conv_done_n_n_q <= last_conv_done_n_n_d;
		end
	end

	assign conv_done_n = eoc_n_q;
	assign last_conv_done_n = last_conv_done_n_n_q;
	assign sample_ready = fifo_ready;

	//------------------------------------------------------------
	// result buffer and read-out
	//------------------------------------------------------------
	logic fifo_valid, rd_act, rd_act_prev_q, pop;
	logic [DATA_W-1:0] fifo_data, bus_q, bus_d;

	// select and read low together, order of their fall irrelevant
	assign rd_act = !cs_q && !rd_q; // RQ16 RQ18 RQ20
	// one word consumed per read, taken when read ends
	assign pop = rd_act_prev_q && !rd_act && fifo_valid; // RQ17

	acr_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_valid(fifo_push),
		.in_ready(fifo_ready),
		.in_data(held_q),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	always_comb begin
		bus_d = bus_q;
		if (rd_act && !rd_act_prev_q) begin
			bus_d = fifo_valid ? fifo_data : result_q; // RQ17
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus_q <= ACR_RESULT_RST;
			rd_act_prev_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			rd_act_prev_q <= rd_act;
		end
	end

	assign result_bus_o = bus_q;
	// enable follows the strobes only, never power-down
	assign result_bus_oe = rd_act_prev_q && rd_act; // RQ16 RQ20
endmodule

// ===== testbench/acr_chk.sv
// concurrent checks on the conversion and read-out ports
`timescale 1ns/1ps
module acr_chk
	import acr_pkg::*;
#(
	parameter int DATA_W = 12,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys, // clock
	input wire logic resetn, // reset
	input wire logic sample_start, // start
	input wire logic conv_clk_ext, // ext clock
	input wire logic clock_source_select, // strap
	input wire logic power_down, // shutdown
	input wire logic chip_sel_n, // select
	input wire logic read_n, // read
	input wire logic [DATA_W-1:0] sample_value, // value
	input wire logic conv_done_n, // done
	input wire logic last_conv_done_n, // last done
	input wire logic [DATA_W-1:0] result_bus_o, // bus
	input wire logic result_bus_oe, // enable
	input wire logic sample_ready // room
);
	localparam int EOC_MAX = ACR_EOC_MAX_CYC;
	logic [4:0] edges_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ----
	// ext clock edges since sampling
	// ----
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			edges_q <= 5'h00;
		end else if ($rose(sample_start) || $fell(power_down)) begin
			edges_q <= 5'h00;
		end else if ($rose(conv_clk_ext)) begin
			edges_q <= edges_q + 5'h01;
		end
	end
	a_oe_on_read: assert property (
		(!chip_sel_n && !read_n) [*4] |-> result_bus_oe) else $error("bus idle in read");
	a_oe_off_idle: assert property (
		(chip_sel_n || read_n) [*4] |-> !result_bus_oe) else $error("bus driven");
	a_pd_flags_high: assert property (
		power_down [*6] |-> conv_done_n && last_conv_done_n) else $error("flag low in shutdown");
	a_last_holds: assert property (
		(sample_start && !power_down) [*8] ##0 !last_conv_done_n |=> !last_conv_done_n)
		else $error("last flag lost");
	a_start_clears: assert property (
		$fell(sample_start) ##1 !sample_start [*5] |=> conv_done_n && last_conv_done_n)
		else $error("flag not cleared");
	a_int_in_time: assert property (
		$rose(sample_start) && clock_source_select && sample_ready && !power_down
		|-> ##[1:EOC_MAX] (!last_conv_done_n || !sample_start || power_down)) else $error("late");
	a_ext_thirteen: assert property (
		$fell(last_conv_done_n) && !clock_source_select |-> edges_q == 5'h0D) else $error("count");
	a_pd_launch: assert property (
		$fell(power_down) && clock_source_select && sample_ready && sample_start
		|-> ##[1:100] (!last_conv_done_n || power_down)) else $error("no launch");
endmodule

// ===== testbench/acr_host.sv
// host side model: external conversion clock in bursts
`timescale 1ns/1ps
module acr_host (
	input wire logic clk_sys, // system clock
	output logic conv_clk_ext // conversion clock pin
);
	initial conv_clk_ext = 1'b0;
	// n pulses of half period h clocks, still between bursts
	task automatic burst(input int n, input int h);
		repeat (n) begin
			repeat (h) @(posedge clk_sys);
			#1 conv_clk_ext = 1'b1;
			repeat (h) @(posedge clk_sys);
			#1 conv_clk_ext = 1'b0;
		end
	endtask
endmodule

// ===== testbench/acr_tb_top.sv
// testbench: conversion, read-out, shutdown and buffering sequences
`timescale 1ns/1ps
module acr_tb_top;
	import acr_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic sample_start = 1'b1;
	logic clock_source_select = 1'b1;
	logic power_down = 1'b0;
	logic chip_sel_n = 1'b1;
	logic read_n = 1'b1;
	logic [11:0] sample_value = 12'h000;
	logic conv_clk_ext, conv_done_n, last_conv_done_n, result_bus_oe, sample_ready;
	logic [11:0] result_bus_o;
	logic [11:0] st;
	int num_errors = 0;
	int n_checks = 0;
	localparam logic [11:0] VALS [3] = '{12'hA5C, 12'h5A3, 12'hFFF};
	assign st = {8'h00, sample_ready, result_bus_oe, conv_done_n, last_conv_done_n};
	always #5 clk_sys = ~clk_sys;
	acr_host host (.*);
	acr_core DUT (.*);
	// ----
	// access tasks
	// ----
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic rst(input logic strap);
		resetn = 1'b0;
		clock_source_select = strap;
		step(5);
		resetn = 1'b1;
		step(3);
	endtask
	task automatic wdone();
		int i;
		i = 0;
		while (last_conv_done_n !== 1'b0 && i < 120) begin
			step(1);
			i++;
		end
		chk(st & 12'h003, 12'h000);
	endtask
	// h is the ext clock half period, 0 for internal mode
	task automatic conv(input logic [11:0] v, input int h);
		sample_start = 1'b0;
		step(12);
		chk(st & 12'h007, 12'h003);
		sample_value = v;
		sample_start = 1'b1;
		if (h != 0) begin
			step(4);
			host.burst(12, h);
			step(8);
			chk(st & 12'h003, 12'h003);
			host.burst(1, h);
		end
		wdone();
	endtask
	// m: 0 select held low, 1 and 2 select tied to read after m idle cycles
	task automatic rd(input logic [11:0] v, input int m);
		chip_sel_n = (m != 0);
		step(m);
		chip_sel_n = 1'b0;
		read_n = 1'b0;
		step(5);
		chk(st & 12'h004, 12'h004);
		chk(result_bus_o, v);
		chip_sel_n = (m != 0);
		read_n = 1'b1;
		step(6);
		chk(st & 12'h004, 12'h000);
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		rst(1'b1);
		for (int m = 0; m < 3; m++) begin
			conv(VALS[m], 0);
			step(20);
			chk(st & 12'h001, 12'h000);
			rd(VALS[m], m);
		end
		sample_start = 1'b0;
		step(12);
		sample_start = 1'b1;
		step(30);
		conv(12'h3C7, 0);
		rd(12'h3C7, 0);
		power_down = 1'b1;
		step(8);
		chk(st & 12'h003, 12'h003);
		rd(12'h3C7, 0);
		sample_value = 12'h6B1;
		power_down = 1'b0;
		wdone();
		rd(12'h6B1, 0);
		for (int k = 0; k < ACR_FIFO_DEPTH; k++) conv(12'h100 | 12'(k), 0);
		chk(st & 12'h008, 12'h000);
		for (int k = 0; k < ACR_FIFO_DEPTH; k++) rd(12'h100 | 12'(k), 2);
		chk(st & 12'h008, 12'h008);
		rst(1'b0);
		conv(12'h2D4, 5);
		host.burst(1, 5);
		step(6);
		chk(st & 12'h003, 12'h002);
		rd(12'h2D4, 1);
		conv(12'hD2B, 12);
		rd(12'hD2B, 0);
		end_of_test();
	end
	initial begin
		#100us;
		num_errors++;
		end_of_test();
	end
endmodule
bind acr_core acr_chk #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
